// ---- logic/spmc_protect.sv ----
/*
 * spmc_protect: fault protection mode controller with a classic Wishbone register slave.
 * Assumes asynchronous comparator inputs and a single clock with synchronous reset.
 */
// What this block does
// RULE_01 - latch is only released by the supply-below-reset-level indication.
// RULE_02 - supply overvoltage latches only while feedback is high as well.
// RULE_03 - entering the latch switches the internal reference off.
// RULE_04 - while latched, startup cell on below turn-off level, off above turn-on.
// RULE_05 - while latched, reaching turn-on level starts no startup phase or switching.
// RULE_06 - blanked over-temperature indication enters the latch.
// RULE_07 - over-temperature and qualified overvoltage must stand 8.0 us before latching.
// RULE_08 - secondary short comparator enters the latch at once.
// RULE_09 - high feedback opens the soft-start clamp switch.
// RULE_10 - auto restart on overload needs both feedback high and soft-start high.
// RULE_11 - supply undervoltage enters auto restart and a new startup cycle.
// RULE_12 - auto restart always runs a switching startup phase, then re-checks fault.
// RULE_13 - normal operation resumes when the fault is gone after a startup phase.
// RULE_14 - comparators are synchronised; blanking counted in cycles from clock rate.
// RULE_15 - latch has priority over auto restart and is never overridden by it.
`timescale 1ns/1ps
`default_nettype none

module spmc_protect
	import spmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire spmc_cmp_t cmp_i,
	output spmc_pwr_t pwr_o,
	output logic [2:0] mode_o,
	output logic irq_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	spmc_regs_t q;
	spmc_regs_t d;

	////////////////////////////////////////////////////////////////////////////
	// synchronised view of the comparators and blanked latch sources

	spmc_cmp_t cmp_s;
	logic [NUM_BLANK-1:0] blank_in;
	logic [NUM_BLANK-1:0] blank_out;
	logic ov_blanked;
	logic ot_blanked;
	logic short_hit;
	logic latch_req;
	logic overload;
	logic undervoltage_lockout;
	logic turn_on;
	logic reset_lvl;

	assign cmp_s = spmc_cmp_t'(q.sync2);

	// overvoltage only counts with feedback out of range
	assign blank_in[0] = cmp_s.supply_overvoltage_cmp & cmp_s.feedback_high_cmp; // RULE_02
	assign blank_in[1] = cmp_s.over_temp_cmp;

	generate
		for (genvar i = 0; i < NUM_BLANK; i++) begin : g_blank
			spmc_blank_filter u_blank (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.level_i(blank_in[i]),
				.level_o(blank_out[i])
			); // RULE_07
		end
	endgenerate

	assign ov_blanked = blank_out[0]; // RULE_02
	assign ot_blanked = blank_out[1]; // RULE_06
	// the short path has its own analog spike filter, so no extra blanking here
	assign short_hit = cmp_s.secondary_short_cmp; // RULE_08
	assign latch_req = ov_blanked | ot_blanked | short_hit;
	// restart_entry_gate: both inputs high
	assign overload = cmp_s.feedback_high_cmp & cmp_s.soft_start_high_cmp; // RULE_10
	assign undervoltage_lockout = cmp_s.supply_undervoltage_cmp;
	assign turn_on = cmp_s.supply_turn_on_cmp;
	assign reset_lvl = cmp_s.supply_reset_cmp;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic wb_req;
	logic wb_wr;
	logic [NUM_EV-1:0] irq_clr;

	assign wb_req = wb_cyc_i & wb_stb_i;
	// writes land on the edge where the master sees ack
	assign wb_wr = wb_req & wb_we_i & q.ack & wb_sel_i[0];
	assign irq_clr = (wb_wr && wb_adr_i == REG_IRQ_CLEAR) ? wb_dat_i[NUM_EV-1:0] : '0;

	function automatic logic [31:0] rd_word(input spmc_regs_t r, input logic [7:0] adr);
		logic [31:0] w;
		w = '0;
		case (adr)
			REG_STATUS: begin
				w[2:0] = r.state;
				w[5:3] = r.latch_cause;
				w[7:6] = r.restart_cause;
				w[15:8] = r.sync2;
				w[19:16] = r.pwr;
			end
			REG_IRQ_STATUS: begin
				w[NUM_EV-1:0] = r.irq_sts;
			end
			REG_IRQ_ENABLE: begin
				w[NUM_EV-1:0] = r.irq_en;
			end
			REG_CONTROL: begin
				w[0] = r.run_en;
			end
			REG_RESTART_CNT: begin
				w[7:0] = r.restart_cnt;
			end
			default: begin
				w = '0;
			end
		endcase
		return w;
	endfunction : rd_word

	////////////////////////////////////////////////////////////////////////////
	// next state

	logic [NUM_EV-1:0] ev;

	always_comb begin
		d = q;
		ev = '0;

		// two-stage synchroniser for every comparator
		d.sync1 = cmp_i; // RULE_14
		d.sync2 = q.sync1; // RULE_14

		if (q.tmr != '0) begin
			d.tmr = q.tmr - 1'b1;
		end

		if (q.state != ST_LATCHED && latch_req) begin
			// checked ahead of every restart path
			d.state = ST_LATCHED; // RULE_15
			d.latch_cause = {short_hit, ot_blanked, ov_blanked}; // RULE_06
			d.restart_cause = '0;
			d.tmr = '0;
			ev[EV_LATCH] = 1'b1;
		end else begin
			case (q.state)
				ST_OFF: begin
					// charge from the startup cell until turn-on level
					if (undervoltage_lockout) begin
						d.pwr.startup_cell_en = 1'b1;
					end
					if (q.run_en && q.pwr.startup_cell_en && turn_on) begin
						d.state = ST_START;
						d.tmr = TMR_W'(START_CYC);
					end
				end
				ST_START: begin
					if (undervoltage_lockout) begin
						// no self supply yet, e.g. optocoupler shorted
						d.state = ST_RESTART; // RULE_11
						d.restart_cause = 2'b10;
						d.pwr.startup_cell_en = 1'b1;
						ev[EV_RESTART] = 1'b1;
					end else if (q.tmr == '0) begin
						// startup phase over, look at the fault again
						if (overload) begin
							d.state = ST_RESTART; // RULE_12
							d.restart_cause = 2'b01;
							ev[EV_RESTART] = 1'b1;
						end else begin
							d.state = ST_NORMAL; // RULE_13
							d.restart_cause = '0;
							ev[EV_NORMAL] = 1'b1;
						end
					end
				end
				ST_NORMAL: begin
					if (undervoltage_lockout) begin
						d.state = ST_RESTART; // RULE_11
						d.restart_cause = 2'b10;
						d.pwr.startup_cell_en = 1'b1;
						ev[EV_RESTART] = 1'b1;
					end else if (overload) begin
						d.state = ST_RESTART; // RULE_10
						d.restart_cause = 2'b01;
						ev[EV_RESTART] = 1'b1;
					end
				end
				ST_RESTART: begin
					// switching stops, supply drains, cell recharges, then restart
					if (undervoltage_lockout) begin
						d.pwr.startup_cell_en = 1'b1;
					end
					if (q.run_en && q.pwr.startup_cell_en && turn_on) begin
						d.state = ST_START; // RULE_12
						d.tmr = TMR_W'(START_CYC);
					end
				end
				ST_LATCHED: begin
					// only the undervoltage lockout keeps running here
					if (undervoltage_lockout) begin
						d.pwr.startup_cell_en = 1'b1; // RULE_04
					end else if (turn_on) begin
						d.pwr.startup_cell_en = 1'b0; // RULE_05
					end
					if (reset_lvl) begin
						d.state = ST_OFF; // RULE_01
						d.latch_cause = '0;
						d.pwr.startup_cell_en = 1'b1;
						ev[EV_RELEASE] = 1'b1;
					end
				end
				default: begin
					d.state = ST_OFF;
				end
			endcase
		end

		if (ev[EV_RESTART] && q.restart_cnt != 8'hFF) begin
			d.restart_cnt = q.restart_cnt + 1'b1;
		end

		// outputs follow the next state so they switch with it
		case (d.state)
			ST_START, ST_NORMAL: begin
				d.pwr.switching_en = 1'b1;
				d.pwr.startup_cell_en = 1'b0;
				d.pwr.reference_en = 1'b1;
			end
			ST_LATCHED: begin
				d.pwr.switching_en = 1'b0; // RULE_05
				d.pwr.reference_en = 1'b0; // RULE_03
			end
			default: begin
				d.pwr.switching_en = 1'b0;
				d.pwr.reference_en = 1'b1;
			end
		endcase
		// clamp open when feedback is high, except in off and latched where it stays closed
		d.pwr.soft_start_clamp_switch = ~cmp_s.feedback_high_cmp; // RULE_09
		if (d.state == ST_LATCHED || d.state == ST_OFF) begin
			d.pwr.soft_start_clamp_switch = 1'b1;
		end
		if (q.state != ST_LATCHED && d.state == ST_LATCHED) begin
			// cell switches off on entry, until the supply crosses a level
			d.pwr.startup_cell_en = 1'b0;
		end

		// sticky status, a new event beats a clear in the same cycle
		d.irq_sts = (q.irq_sts & ~irq_clr) | ev;

		if (wb_wr && wb_adr_i == REG_IRQ_ENABLE) begin
			d.irq_en = wb_dat_i[NUM_EV-1:0];
		end
		if (wb_wr && wb_adr_i == REG_CONTROL) begin
			d.run_en = wb_dat_i[0];
		end

		// one wait state, ack for exactly one cycle
		d.ack = wb_req & ~q.ack;
		if (wb_req && !q.ack) begin
			d.rdat = rd_word(q, wb_adr_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= REGS_RST;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign pwr_o = q.pwr;
	assign mode_o = q.state;
	assign irq_o = |(q.irq_sts & q.irq_en);
	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;

endmodule : spmc_protect

`default_nettype wire

// ---- shared/spmc_pkg.sv ----
/*
 * spmc_pkg: constants, types and reset values of the protection mode controller.
 * Assumes a single 40 MHz clock and a classic Wishbone slave with byte addresses.
 */
`default_nettype none

package spmc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int unsigned CLK_FREQ_HZ = 40_000_000;
	localparam int unsigned CLK_MHZ = CLK_FREQ_HZ / 1_000_000;
	// spike blanking of 8.0 us, held in ns
	localparam int unsigned BLANK_TIME_NS = 8000;
	localparam int unsigned BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned BLANK_CNT_W = 9;
	localparam int unsigned START_PHASE_US = 50;
	localparam int unsigned START_CYC = START_PHASE_US * CLK_MHZ;
	localparam int unsigned TMR_W = 12;
	localparam int unsigned NUM_BLANK = 2;

	////////////////////////////////////////////////////////////////////////////
	// register map, byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h08;
	localparam logic [7:0] REG_IRQ_ENABLE = 8'h0C;
	localparam logic [7:0] REG_CONTROL = 8'h10;
	localparam logic [7:0] REG_RESTART_CNT = 8'h14;

	// interrupt event bit positions
	localparam int unsigned EV_LATCH = 0;
	localparam int unsigned EV_RESTART = 1;
	localparam int unsigned EV_NORMAL = 2;
	localparam int unsigned EV_RELEASE = 3;
	localparam int unsigned NUM_EV = 4;

	// reset values
	localparam logic [NUM_EV-1:0] IRQ_EN_RST = 4'h0;
	localparam logic RUN_EN_RST = 1'b1;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [2:0] {
		ST_OFF,
		ST_START,
		ST_NORMAL,
		ST_RESTART,
		ST_LATCHED
	} spmc_state_t;

	// digitised comparator outputs, all asynchronous to clk_i
	typedef struct packed {
		logic supply_reset_cmp;
		logic supply_turn_on_cmp;
		logic supply_undervoltage_cmp;
		logic over_temp_cmp;
		logic secondary_short_cmp;
		logic soft_start_high_cmp;
		logic feedback_high_cmp;
		logic supply_overvoltage_cmp;
	} spmc_cmp_t;

	typedef struct packed {
		logic switching_en;
		logic soft_start_clamp_switch;
		logic reference_en;
		logic startup_cell_en;
	} spmc_pwr_t;

	typedef struct packed {
		logic [BLANK_CNT_W-1:0] cnt;
		logic hit;
	} spmc_blank_t;

	typedef struct packed {
		spmc_state_t state;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [TMR_W-1:0] tmr;
		logic [2:0] latch_cause;
		logic [1:0] restart_cause;
		logic [NUM_EV-1:0] irq_sts;
		logic [NUM_EV-1:0] irq_en;
		logic run_en;
		logic [7:0] restart_cnt;
		spmc_pwr_t pwr;
		logic ack;
		logic [31:0] rdat;
	} spmc_regs_t;

	localparam spmc_blank_t BLANK_RST = '{cnt: '0, hit: 1'b0};
	localparam spmc_pwr_t PWR_RST = '{switching_en: 1'b0, soft_start_clamp_switch: 1'b1,
		reference_en: 1'b1, startup_cell_en: 1'b1};
	localparam spmc_regs_t REGS_RST = '{state: ST_OFF, sync1: '0, sync2: '0, tmr: '0,
		latch_cause: '0, restart_cause: '0, irq_sts: '0, irq_en: IRQ_EN_RST,
		run_en: RUN_EN_RST, restart_cnt: '0, pwr: PWR_RST, ack: 1'b0, rdat: '0};

endpackage : spmc_pkg

`default_nettype wire

// ---- logic/spmc_blank_filter.sv ----
/*
 * spmc_blank_filter: passes a level only after it has stood high for the blanking time.
 * Assumes level_i is already synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module spmc_blank_filter
	import spmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic level_i,
	output logic level_o
);

	spmc_blank_t q;
	spmc_blank_t d;

	////////////////////////////////////////////////////////////////////////////
	// any drop restarts the count, so short pulses never reach the output
	always_comb begin
		d = q;
		if (!level_i) begin
			d.cnt = '0;
			d.hit = 1'b0;
		end else if (q.cnt == BLANK_CNT_W'(BLANK_CYC - 1)) begin
			d.hit = 1'b1; // RULE_07
		end else begin
			d.cnt = q.cnt + 1'b1; // RULE_07
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= BLANK_RST;
		end else begin
			q <= d;
		end
	end

	assign level_o = q.hit;

endmodule : spmc_blank_filter

`default_nettype wire

// ---- tb/spmc_protect_props.sv ----
/* spmc_protect_props: assertions on the mode controller ports.
 * Assumes a bind to spmc_protect; mode codes 0 off, 1 start, 2 normal, 3 restart, 4 latched. */
`timescale 1ns/1ps
`default_nettype none
module spmc_protect_props
	import spmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire spmc_cmp_t cmp_i,
	input wire spmc_pwr_t pwr_o,
	input wire logic [2:0] mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] sh_q;
	logic [3:0] rs_q;
	logic [9:0] bc_q;
	logic ovl;
	logic blk;
	assign ovl = (cmp_i.feedback_high_cmp & cmp_i.soft_start_high_cmp)
		| cmp_i.supply_undervoltage_cmp;
	assign blk = cmp_i.over_temp_cmp | (cmp_i.supply_overvoltage_cmp & cmp_i.feedback_high_cmp);
	////////////////////////////////////////////////////////////////////////////////
	// recent-cause windows cover the synchroniser delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sh_q <= 4'h0;
			rs_q <= 4'h0;
			bc_q <= 10'h000;
		end else begin
			sh_q <= {sh_q[2:0], cmp_i.secondary_short_cmp};
			rs_q <= {rs_q[2:0], ovl};
			bc_q <= blk ? bc_q + {9'h000, bc_q != 10'h3FF} : 10'h000;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence s_short_held;
		(cmp_i.secondary_short_cmp && !cmp_i.supply_reset_cmp)[*3];
	endsequence
	sequence s_latch_held;
		(mode_o == 3'h4 && !cmp_i.supply_reset_cmp)[*3];
	endsequence
	chk_latch_hold: assert property (s_latch_held |=> mode_o == 3'h4)
		else $error("latch left without supply reset");
	chk_latch_exit: assert property (mode_o == 3'h4 |=> mode_o inside {3'h0, 3'h4})
		else $error("latch left to a running mode");
	chk_latch_quiet: assert property (
		mode_o == 3'h4 |-> !pwr_o.reference_en && !pwr_o.switching_en)
		else $error("reference or switching on while latched");
	chk_short_entry: assert property (s_short_held |=> mode_o == 3'h4)
		else $error("short did not latch");
	chk_latch_cause: assert property (
		mode_o == 3'h4 && $past(mode_o) != 3'h4 |-> (|sh_q) || bc_q >= 10'h140)
		else $error("latch without blanked cause");
	chk_restart_cause: assert property (
		mode_o == 3'h3 && $past(mode_o) != 3'h3 |-> |rs_q)
		else $error("restart without overload or undervoltage");
	chk_clamp_open: assert property (
		(cmp_i.feedback_high_cmp && mode_o == 3'h2)[*4] |-> !pwr_o.soft_start_clamp_switch)
		else $error("clamp closed with feedback high");
	chk_cell_on: assert property (
		(mode_o == 3'h4 && cmp_i.supply_undervoltage_cmp)[*4] |-> pwr_o.startup_cell_en)
		else $error("cell off below turn-off level");
	chk_cell_off: assert property (
		(mode_o == 3'h4 && cmp_i.supply_turn_on_cmp)[*4] |-> !pwr_o.startup_cell_en)
		else $error("cell on above turn-on level");
	chk_start_switch: assert property (
		mode_o == 3'h1 |-> pwr_o.switching_en && !pwr_o.startup_cell_en)
		else $error("startup phase without switching");
endmodule : spmc_protect_props
bind spmc_protect spmc_protect_props i_spmc_protect_props (.clk_i(clk_i), .rst_i(rst_i),
	.cmp_i(cmp_i), .pwr_o(pwr_o), .mode_o(mode_o));
`default_nettype wire

// ---- tb/spmc_analog_model.sv ----
/* spmc_analog_model: comparators and supply rail around the controller.
 * Assumes vcc in 0.1 V units; the rail charges while the cell or switching runs. */
`timescale 1ns/1ps
`default_nettype none
module spmc_analog_model
	import spmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic hold_i,
	input wire logic [7:0] vcc_set_i,
	input wire logic [3:0] flt_i,
	input wire spmc_pwr_t pwr_i,
	output spmc_cmp_t cmp_o
);
	logic [7:0] vcc_q = 8'h00;
	logic [1:0] div_q = 2'h0;
	logic chg;
	assign chg = pwr_i.startup_cell_en | pwr_i.switching_en;
	// slow ramp so every threshold stands for many clocks
	always @(posedge clk_i) begin
		div_q <= div_q + 2'h1;
		if (hold_i)
			vcc_q <= vcc_set_i;
		else if (div_q == 2'h0 && chg && vcc_q < 8'hB4)
			vcc_q <= vcc_q + 8'h01;
		else if (div_q == 2'h0 && !chg && vcc_q != 8'h00)
			vcc_q <= vcc_q - 8'h01;
	end
	assign cmp_o = {vcc_q < 8'h3C, vcc_q > 8'h96, vcc_q < 8'h55, flt_i, vcc_q > 8'hD2};
endmodule : spmc_analog_model
`default_nettype wire

// ---- tb/spmc_protect_tb_top.sv ----
/* spmc_protect_tb_top: directed tests of the protection mode controller.
 * Assumes the analog model and the bound checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module spmc_protect_tb_top
	import spmc_pkg::*;
;
	logic clk_i;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic hold = 1'b1;
	logic irq, ack;
	logic [2:0] mode;
	logic [3:0] flt = 4'h0;
	logic [7:0] adr = 8'h00;
	logic [7:0] vset = 8'h00;
	logic [31:0] wdat = 32'h0, dout, rdat;
	spmc_cmp_t cmp;
	spmc_pwr_t pwr;
	int fails = 0;
	int total_checks = 0;
	spmc_analog_model i_spmc_analog_model (.clk_i(clk_i), .hold_i(hold), .vcc_set_i(vset),
		.flt_i(flt), .pwr_i(pwr), .cmp_o(cmp));
	spmc_protect i_spmc_protect (.clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp), .pwr_o(pwr),
		.mode_o(mode), .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask : chk
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		chk(ack, 1'b1);
		rdat = dout;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task wmode(input logic [2:0] m, input int lim);
		int n;
		n = 0;
		while (mode !== m && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		chk(mode, m);
	endtask : wmode
	task wcell(input logic v);
		int n;
		n = 0;
		while (pwr.startup_cell_en !== v && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		chk(pwr.startup_cell_en, v);
		chk(mode, 3'h4);
		chk(pwr.switching_en, 1'b0);
	endtask : wcell
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		wb(1'b0, REG_IRQ_ENABLE, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b1, REG_IRQ_ENABLE, 32'h0000000F);
		wb(1'b0, REG_IRQ_ENABLE, 32'h0);
		chk(rdat, 32'h0000000F);
		wb(1'b0, 8'h20, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b0, REG_CONTROL, 32'h0);
		chk(rdat, 32'h00000001);
		$display("regs test done");
	endtask : t_regs
	task t_up;
		// run enable low must keep the block in off although the rail is up
		wb(1'b1, REG_CONTROL, 32'h0);
		hold <= 1'b0;
		repeat (800) @(posedge clk_i);
		chk(mode, 3'h0);
		chk(pwr.switching_en, 1'b0);
		wb(1'b1, REG_CONTROL, 32'h1);
		wmode(3'h2, 4000);
		chk(pwr, 4'hE);
		chk(irq, 1'b1);
		wb(1'b1, REG_IRQ_CLEAR, 32'h0000000F);
		chk(irq, 1'b0);
		$display("power-up test done");
	endtask : t_up
	task t_overload;
		flt <= 4'h1;
		repeat (8) @(posedge clk_i);
		chk(pwr.soft_start_clamp_switch, 1'b0);
		chk(mode, 3'h2);
		flt <= 4'h3;
		wmode(3'h3, 8);
		repeat (2) @(posedge clk_i);
		chk(irq, 1'b1);
		wb(1'b0, REG_IRQ_STATUS, 32'h0);
		chk(rdat, 32'h1 << EV_RESTART);
		wb(1'b0, REG_RESTART_CNT, 32'h0);
		chk(rdat, 32'h1);
		wb(1'b1, REG_IRQ_ENABLE, 32'h0);
		chk(irq, 1'b0);
		wb(1'b1, REG_IRQ_CLEAR, 32'h0000000F);
		wb(1'b1, REG_IRQ_ENABLE, 32'h0000000F);
		chk(irq, 1'b0);
		flt <= 4'h0;
		wmode(3'h1, 1000);
		chk(pwr.switching_en, 1'b1);
		wmode(3'h2, 2100);
		$display("overload test done");
	endtask : t_overload
	task t_ov;
		hold <= 1'b1;
		vset <= 8'hDC;
		repeat (400) @(posedge clk_i);
		chk(mode, 3'h2);
		flt <= 4'h1;
		repeat (200) @(posedge clk_i);
		flt <= 4'h0;
		repeat (10) @(posedge clk_i);
		chk(mode, 3'h2);
		flt <= 4'h1;
		repeat (300) @(posedge clk_i);
		chk(mode, 3'h2);
		wmode(3'h4, 40);
		chk(pwr.reference_en, 1'b0);
		wb(1'b0, REG_STATUS, 32'h0);
		chk(rdat[5:0], 6'h0C);
		flt <= 4'h0;
		hold <= 1'b0;
		wcell(1'b1);
		wcell(1'b0);
		hold <= 1'b1;
		vset <= 8'h32;
		wmode(3'h0, 10);
		$display("latch test done");
	endtask : t_ov
	task t_causes;
		for (int i = 0; i < 2; i++) begin
			hold <= 1'b0;
			wmode(3'h2, 3000);
			if (i == 0) begin
				flt <= 4'h8;
				repeat (100) @(posedge clk_i);
				flt <= 4'h0;
				repeat (10) @(posedge clk_i);
				chk(mode, 3'h2);
				flt <= 4'h8;
				wmode(3'h4, 340);
			end else begin
				flt <= 4'h7;
				wmode(3'h4, 6);
			end
			flt <= 4'h0;
			hold <= 1'b1;
			vset <= 8'h32;
			wmode(3'h0, 10);
		end
		$display("causes test done");
	endtask : t_causes
	////////////////////////////////////////////////////////////////////////////////
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		#1500000;
		fails++;
		conclude;
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_up;
		t_overload;
		t_ov;
		t_causes;
		conclude;
	end
endmodule : spmc_protect_tb_top
`default_nettype wire
